/* File: shared/rpm_regs.svh */
`ifndef RPM_REGS_SVH
`define RPM_REGS_SVH

// ----------------------------------------------------------------
// Register offsets, word index on the plain register port.
// ----------------------------------------------------------------
`define RPM_OFF_MUX 4'h0
`define RPM_OFF_DIR 4'h1
`define RPM_OFF_DOUT 4'h2
`define RPM_OFF_PIN 4'h3
`define RPM_OFF_PULL 4'h4
`define RPM_OFF_RST 4'h5

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define RPM_BIT_RPIN 7
`define RPM_BIT_SWRST 15
`define RPM_CAUSE_POR 0
`define RPM_CAUSE_EXT 1
`define RPM_CAUSE_WDOG 2
`define RPM_CAUSE_SW 3

// ----------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------
`define RPM_RST_PULL 5'h1F
`define RPM_RST_CAUSE 4'h1
`define RPM_RELEASE_CYC 8'h20

`endif

/* File: shared/rpm_pkg.sv */
package rpm_pkg;

	// ------------------------------------------------------------
	// Reset sequencer states.
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RPM_RUN = 2'b00,
		RPM_HOLD = 2'b01,
		RPM_COUNT = 2'b10
	} rpm_rst_state_t;

	// ------------------------------------------------------------
	// Whole state of the pin mux.
	// ------------------------------------------------------------
	typedef struct packed {
		rpm_rst_state_t rst_st;
		logic [7:0] rst_cnt;
		logic sw_req;
		logic [3:0] alt_sel;
		logic rst_gpio;
		logic [3:0] dir;
		logic rp_dir;
		logic [3:0] dout;
		logic rp_dout;
		logic [4:0] pull;
		logic [4:0] pin_in;
		logic [3:0] cause;
		logic [3:0] pa_out;
		logic [3:0] pa_oe;
		logic [3:0] pa_pu;
		logic rp_out;
		logic rp_oe;
		logic rp_pu;
		logic chip_rst_b;
		logic [15:0] rd_data;
	} rpm_state_t;

endpackage

/* File: core/rpm_pin_mux.sv */
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "rpm_regs.svh"
// Contract
// R1 - On leaving reset every pin takes its first-listed function unaided.
// R2 - Software must program a pin's selection before any alternate is used.
// R3 - While the external reset pin is low the chip is held in reset.
// R4 - Internal reset is released on the clock a fixed count after release.
// R5 - A reset pin in GPIO mode is input or open-drain, never driven high.
// R6 - A reset pin in GPIO mode is no longer a source of chip reset.
// R7 - Then only power-on, watchdog and software reset can reset the chip.
// R8 - Any reset returns the shared pin to its external reset function.
// R9 - In GPIO mode port bits zero to three each have their own direction.
// R10 - Alternate mode drives modulator channel N out on port bit N.
// R11 - After reset port bits zero to three are in GPIO mode.
// R12 - Function selection comes from control bits in this unit.
// R13 - During reset pins are inputs with pull-ups on and drivers off.
module rpm_pin_mux (
	// Clock and power-on reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Reset sources and chip reset
	input wire logic watchdog_reset_source,
	output logic chip_rst_b,
	// Modulator channels
	input wire logic modulator_out_0,
	input wire logic modulator_out_1,
	input wire logic modulator_out_2,
	input wire logic modulator_out_3,
	// Shared reset pin
	input wire logic port_a_bit7_io_in,
	output logic port_a_bit7_io_out,
	output logic port_a_bit7_io_oe,
	output logic port_a_bit7_io_pu,
	// Port bit 0
	input wire logic port_a_bit0_io_in,
	output logic port_a_bit0_io_out,
	output logic port_a_bit0_io_oe,
	output logic port_a_bit0_io_pu,
	// Port bit 1
	input wire logic port_a_bit1_io_in,
	output logic port_a_bit1_io_out,
	output logic port_a_bit1_io_oe,
	output logic port_a_bit1_io_pu,
	// Port bit 2
	input wire logic port_a_bit2_io_in,
	output logic port_a_bit2_io_out,
	output logic port_a_bit2_io_oe,
	output logic port_a_bit2_io_pu,
	// Port bit 3
	input wire logic port_a_bit3_io_in,
	output logic port_a_bit3_io_out,
	output logic port_a_bit3_io_oe,
	output logic port_a_bit3_io_pu
);

	// ------------------------------------------------------------
	// Reset value of the whole state.
	// ------------------------------------------------------------
	localparam rpm_pkg::rpm_state_t RST_VAL = '{
		rst_st: rpm_pkg::RPM_HOLD,
		rst_cnt: 8'h00,
		sw_req: 1'b0,
		alt_sel: 4'h0,
		rst_gpio: 1'b0,
		dir: 4'h0,
		rp_dir: 1'b0,
		dout: 4'h0,
		rp_dout: 1'b0,
		pull: `RPM_RST_PULL,
		pin_in: 5'h1F,
		cause: `RPM_RST_CAUSE,
		pa_out: 4'h0,
		pa_oe: 4'h0,
		pa_pu: 4'hF,
		rp_out: 1'b0,
		rp_oe: 1'b0,
		rp_pu: 1'b1,
		chip_rst_b: 1'b0,
		rd_data: 16'h0000
	};

	rpm_pkg::rpm_state_t st_r;
	rpm_pkg::rpm_state_t st_nxt;
	logic [3:0] mod_v;
	logic [3:0] pa_in_v;
	logic [3:0] mux_out;
	logic [3:0] mux_oe;
	logic [3:0] mux_pu;
	logic ext_rst;
	logic any_src;
	logic in_rst;
	logic [3:0] cause_set;
	logic [3:0] cause_clr;
	logic wr_ok;

	// ------------------------------------------------------------
	// Reset sources.
	// ------------------------------------------------------------
	assign ext_rst = !st_r.rst_gpio && !st_r.pin_in[4]; // [R3] [R6]
	assign any_src = ext_rst || watchdog_reset_source || st_r.sw_req; // [R7]
	assign in_rst = any_src || (st_r.rst_st != rpm_pkg::RPM_RUN);

	assign mod_v = {modulator_out_3, modulator_out_2,
		modulator_out_1, modulator_out_0};
	assign pa_in_v = {port_a_bit3_io_in, port_a_bit2_io_in,
		port_a_bit1_io_in, port_a_bit0_io_in};

	// ------------------------------------------------------------
	// Per-bit function select for port bits zero to three.
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_bit
			assign mux_out[gi] = st_r.alt_sel[gi] ?
				mod_v[gi] : st_r.dout[gi]; // [R10] [R12]
			assign mux_oe[gi] = in_rst ? 1'b0 :
				(st_r.alt_sel[gi] || st_r.dir[gi]); // [R9] [R13]
			assign mux_pu[gi] = in_rst ? 1'b1 :
				(st_r.pull[gi] && !mux_oe[gi]); // [R13]
		end
	endgenerate

	// ------------------------------------------------------------
	// Next state.
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_data = 16'h0000;
		st_nxt.sw_req = 1'b0;
		st_nxt.pin_in = {port_a_bit7_io_in, pa_in_v};
		cause_set = 4'h0;
		cause_clr = 4'h0;
		cause_set[`RPM_CAUSE_EXT] = ext_rst;
		cause_set[`RPM_CAUSE_WDOG] = watchdog_reset_source;
		cause_set[`RPM_CAUSE_SW] = st_r.sw_req;
		wr_ok = reg_wr && !in_rst;

		// --------------------------------------------------------
		// Reset sequencer.
		// --------------------------------------------------------
		case (st_r.rst_st)
			rpm_pkg::RPM_RUN: begin
				if (any_src) begin
					st_nxt.rst_st = rpm_pkg::RPM_HOLD; // [R3]
				end
			end
			rpm_pkg::RPM_HOLD: begin
				st_nxt.rst_cnt = 8'h00;
				if (!any_src) begin
					st_nxt.rst_st = rpm_pkg::RPM_COUNT;
				end
			end
			rpm_pkg::RPM_COUNT: begin
				if (any_src) begin
					st_nxt.rst_st = rpm_pkg::RPM_HOLD;
				end else if (st_r.rst_cnt ==
					`RPM_RELEASE_CYC - 8'h01) begin
					st_nxt.rst_st = rpm_pkg::RPM_RUN; // [R4]
				end else begin
					st_nxt.rst_cnt = st_r.rst_cnt + 8'h01; // [R4]
				end
			end
			default: begin
				st_nxt.rst_st = rpm_pkg::RPM_HOLD;
			end
		endcase

		// --------------------------------------------------------
		// Register writes.
		// --------------------------------------------------------
		if (wr_ok) begin
			case (reg_addr)
				`RPM_OFF_MUX: begin
					st_nxt.alt_sel = reg_wdata[3:0]; // [R2] [R12]
					st_nxt.rst_gpio = reg_wdata[`RPM_BIT_RPIN];
				end
				`RPM_OFF_DIR: begin
					st_nxt.dir = reg_wdata[3:0]; // [R9]
					st_nxt.rp_dir = reg_wdata[`RPM_BIT_RPIN]; // [R5]
				end
				`RPM_OFF_DOUT: begin
					st_nxt.dout = reg_wdata[3:0];
					st_nxt.rp_dout = reg_wdata[`RPM_BIT_RPIN];
				end
				`RPM_OFF_PULL: begin
					st_nxt.pull = {reg_wdata[`RPM_BIT_RPIN],
						reg_wdata[3:0]};
				end
				`RPM_OFF_RST: begin
					cause_clr = reg_wdata[3:0];
					st_nxt.sw_req = reg_wdata[`RPM_BIT_SWRST];
				end
				default: begin
				end
			endcase
		end

		// --------------------------------------------------------
		// Cause flags: a new event wins over a clear.
		// --------------------------------------------------------
		st_nxt.cause = (st_r.cause & ~cause_clr) | cause_set;

		// --------------------------------------------------------
		// Any reset source restores the mux, direction, output and pull defaults.
		// --------------------------------------------------------
		if (any_src) begin
			st_nxt.alt_sel = 4'h0; // [R1] [R11]
			st_nxt.rst_gpio = 1'b0; // [R8]
			st_nxt.dir = 4'h0; // [R13]
			st_nxt.rp_dir = 1'b0;
			st_nxt.dout = 4'h0;
			st_nxt.rp_dout = 1'b0;
			st_nxt.pull = `RPM_RST_PULL; // [R13]
		end

		// --------------------------------------------------------
		// Register reads.
		// --------------------------------------------------------
		if (reg_rd) begin
			case (reg_addr)
				`RPM_OFF_MUX: begin
					st_nxt.rd_data[3:0] = st_r.alt_sel;
					st_nxt.rd_data[`RPM_BIT_RPIN] = st_r.rst_gpio;
				end
				`RPM_OFF_DIR: begin
					st_nxt.rd_data[3:0] = st_r.dir;
					st_nxt.rd_data[`RPM_BIT_RPIN] = st_r.rp_dir;
				end
				`RPM_OFF_DOUT: begin
					st_nxt.rd_data[3:0] = st_r.dout;
					st_nxt.rd_data[`RPM_BIT_RPIN] = st_r.rp_dout;
				end
				`RPM_OFF_PIN: begin
					st_nxt.rd_data[3:0] = st_r.pin_in[3:0];
					st_nxt.rd_data[`RPM_BIT_RPIN] = st_r.pin_in[4];
				end
				`RPM_OFF_PULL: begin
					st_nxt.rd_data[3:0] = st_r.pull[3:0];
					st_nxt.rd_data[`RPM_BIT_RPIN] = st_r.pull[4];
				end
				`RPM_OFF_RST: begin
					st_nxt.rd_data[3:0] = st_r.cause;
				end
				default: begin
				end
			endcase
		end

		// --------------------------------------------------------
		// Pad drivers.
		// --------------------------------------------------------
		st_nxt.pa_out = mux_out;
		st_nxt.pa_oe = mux_oe; // [R10] [R13]
		st_nxt.pa_pu = mux_pu;
		st_nxt.rp_out = 1'b0; // [R5]
		st_nxt.rp_oe = !in_rst && st_r.rst_gpio &&
			st_r.rp_dir && !st_r.rp_dout; // [R5] [R13]
		st_nxt.rp_pu = (in_rst || !st_r.rst_gpio) ? 1'b1 :
			(st_r.pull[4] && !st_nxt.rp_oe); // [R13]
		st_nxt.chip_rst_b = (st_nxt.rst_st == rpm_pkg::RPM_RUN) &&
			!any_src; // [R3] [R4]
	end

	// ------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= RST_VAL; // [R1] [R8] [R13]
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------
	assign reg_rdata = st_r.rd_data;
	assign chip_rst_b = st_r.chip_rst_b;
	assign port_a_bit7_io_out = st_r.rp_out;
	assign port_a_bit7_io_oe = st_r.rp_oe;
	assign port_a_bit7_io_pu = st_r.rp_pu;
	assign port_a_bit0_io_out = st_r.pa_out[0];
	assign port_a_bit0_io_oe = st_r.pa_oe[0];
	assign port_a_bit0_io_pu = st_r.pa_pu[0];
	assign port_a_bit1_io_out = st_r.pa_out[1];
	assign port_a_bit1_io_oe = st_r.pa_oe[1];
	assign port_a_bit1_io_pu = st_r.pa_pu[1];
	assign port_a_bit2_io_out = st_r.pa_out[2];
	assign port_a_bit2_io_oe = st_r.pa_oe[2];
	assign port_a_bit2_io_pu = st_r.pa_pu[2];
	assign port_a_bit3_io_out = st_r.pa_out[3];
	assign port_a_bit3_io_oe = st_r.pa_oe[3];
	assign port_a_bit3_io_pu = st_r.pa_pu[3];

endmodule

/* File: tb/rpm_pin_mux_monitor.sv */
`timescale 1ns/10ps
`include "rpm_regs.svh"
// ---------------------------------------------------------------
// Port checker of the pin mux.
// ---------------------------------------------------------------
module rpm_pin_mux_monitor (
	// Clock, reset and register port
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic watchdog_reset_source,
	input wire logic chip_rst_b,
	// Pads
	input wire logic port_a_bit7_io_in,
	input wire logic port_a_bit7_io_out,
	input wire logic port_a_bit7_io_oe,
	input wire logic port_a_bit7_io_pu,
	input wire logic port_a_bit0_io_oe,
	input wire logic port_a_bit0_io_pu,
	input wire logic port_a_bit1_io_oe,
	input wire logic port_a_bit2_io_oe,
	input wire logic port_a_bit3_io_oe
);
	logic gpio_md;
	logic [5:0] quiet;
	logic [4:0] oe_all;
	assign oe_all = {port_a_bit7_io_oe, port_a_bit3_io_oe,
		port_a_bit2_io_oe, port_a_bit1_io_oe, port_a_bit0_io_oe};
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gpio_md <= 1'b0;
			quiet <= 6'h00;
		end else begin
			if (!chip_rst_b)
				gpio_md <= 1'b0;
			else if (reg_wr && reg_addr == `RPM_OFF_MUX)
				gpio_md <= reg_wdata[`RPM_BIT_RPIN];
			if (!port_a_bit7_io_in || watchdog_reset_source ||
				(chip_rst_b && reg_wr && reg_addr == `RPM_OFF_RST &&
				reg_wdata[`RPM_BIT_SWRST]))
				quiet <= 6'h00;
			else if (quiet != 6'h3F)
				quiet <= quiet + 6'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	chk_rp_no_high: assert property (
		port_a_bit7_io_oe |-> !port_a_bit7_io_out)
		else $error("reset pin driven high");
	chk_pads_off: assert property (
		!chip_rst_b [*3] |-> oe_all == 5'h00)
		else $error("pad driven in reset");
	chk_pull_on: assert property (
		!chip_rst_b [*3] |-> port_a_bit0_io_pu && port_a_bit7_io_pu)
		else $error("pull-up off in reset");
	chk_rel_count: assert property (
		$rose(chip_rst_b) |-> quiet >= `RPM_RELEASE_CYC)
		else $error("reset released early");
	chk_wdog_rst: assert property (
		watchdog_reset_source |-> ##[1:3] !chip_rst_b)
		else $error("watchdog did not reset");
	chk_pin_rst: assert property (
		!gpio_md && !port_a_bit7_io_in |-> ##[1:3] !chip_rst_b)
		else $error("reset pin ignored");
	chk_exit_inputs: assert property (
		$rose(chip_rst_b) |-> (oe_all == 5'h00) [*2])
		else $error("pad driven on reset exit");
	chk_rd_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data without read");
endmodule

bind rpm_pin_mux rpm_pin_mux_monitor i_rpm_pin_mux_monitor (.*);

/* File: tb/rpm_board.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Board model: resolves each pad from all drivers.
// ---------------------------------------------------------------
module rpm_board (
	// Clock
	input wire logic sys_clk,
	// Device pads
	input wire logic [4:0] oe,
	input wire logic [4:0] out,
	input wire logic [4:0] pu,
	output logic [4:0] pin,
	// Board drivers
	input wire logic [4:0] ext_en,
	input wire logic [4:0] ext_val
);
	logic [4:0] last;
	always_ff @(posedge sys_clk) begin
		last <= pin;
	end
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (oe[i])
				pin[i] = out[i];
			else if (ext_en[i])
				pin[i] = ext_val[i];
			else
				pin[i] = pu[i] | ~last[i];
		end
	end
endmodule

/* File: tb/rpm_pin_mux_tb.sv */
`timescale 1ns/10ps
`include "rpm_regs.svh"
// ---------------------------------------------------------------
// Register-driven test of the pin mux.
// ---------------------------------------------------------------
module rpm_pin_mux_tb;
	logic sys_clk, rst_b, reg_wr, reg_rd, wdog, chip;
	logic [3:0] reg_addr, mod;
	logic [15:0] reg_wdata, reg_rdata;
	logic [4:0] oe, po, pu, pin, ext_en, ext_val;
	int n_mismatch, check_count, cyc, n;
	rpm_pin_mux i_rpm_pin_mux (.sys_clk, .rst_b, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .watchdog_reset_source(wdog),
		.chip_rst_b(chip), .modulator_out_0(mod[0]),
		.modulator_out_1(mod[1]), .modulator_out_2(mod[2]),
		.modulator_out_3(mod[3]), .port_a_bit7_io_in(pin[4]),
		.port_a_bit7_io_out(po[4]), .port_a_bit7_io_oe(oe[4]),
		.port_a_bit7_io_pu(pu[4]), .port_a_bit0_io_in(pin[0]),
		.port_a_bit0_io_out(po[0]), .port_a_bit0_io_oe(oe[0]),
		.port_a_bit0_io_pu(pu[0]), .port_a_bit1_io_in(pin[1]),
		.port_a_bit1_io_out(po[1]), .port_a_bit1_io_oe(oe[1]),
		.port_a_bit1_io_pu(pu[1]), .port_a_bit2_io_in(pin[2]),
		.port_a_bit2_io_out(po[2]), .port_a_bit2_io_oe(oe[2]),
		.port_a_bit2_io_pu(pu[2]), .port_a_bit3_io_in(pin[3]),
		.port_a_bit3_io_out(po[3]), .port_a_bit3_io_oe(oe[3]),
		.port_a_bit3_io_pu(pu[3]));
	rpm_board i_rpm_board (.sys_clk, .oe, .out(po), .pu, .pin, .ext_en,
		.ext_val);
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic wait_run;
		n = 0;
		while (chip !== 1'b1 && n < 80) begin
			tick(1);
			n++;
		end
		tick(2);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		wdog = 1'b0;
		mod = 4'h9;
		ext_en = 5'h0A;
		ext_val = 5'h0A;
		tick(12);
		chk({5'h00, chip, oe, pu}, 16'h001F);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		wait_run;
		chk({15'h0000, n > 31 && n < 40}, 16'h0001);
		rdc(`RPM_OFF_MUX, 16'h0000);
		rdc(`RPM_OFF_PIN, 16'h008F);
		wr(`RPM_OFF_DIR, 16'h0005);
		wr(`RPM_OFF_DOUT, 16'h0001);
		tick(2);
		chk({6'h00, oe, po}, 16'h00A1);
		rdc(`RPM_OFF_PIN, 16'h008B);
		wr(`RPM_OFF_PULL, 16'h0087);
		tick(2);
		chk({11'h000, pu}, 16'h0012);
		rdc(`RPM_OFF_PULL, 16'h0087);
		wr(`RPM_OFF_MUX, 16'h000F);
		tick(2);
		chk({6'h00, oe, po}, 16'h01E9);
		@(posedge sys_clk);
		mod <= 4'h6;
		tick(2);
		chk({6'h00, oe, po}, 16'h01E6);
		wr(`RPM_OFF_MUX, 16'h0080);
		wr(`RPM_OFF_DIR, 16'h0080);
		wr(`RPM_OFF_DOUT, 16'h0000);
		tick(2);
		chk({12'h000, chip, oe[4], po[4], pin[4]}, 16'h000C);
		wr(`RPM_OFF_DOUT, 16'h0080);
		tick(2);
		chk({12'h000, chip, oe[4], po[4], pin[4]}, 16'h0009);
		@(posedge sys_clk);
		ext_en <= 5'h1A;
		tick(6);
		chk({15'h0000, chip}, 16'h0001);
		@(posedge sys_clk);
		ext_en <= 5'h0A;
		wdog <= 1'b1;
		@(posedge sys_clk);
		wdog <= 1'b0;
		tick(3);
		chk({15'h0000, chip}, 16'h0000);
		wait_run;
		rdc(`RPM_OFF_MUX, 16'h0000);
		rdc(`RPM_OFF_RST, 16'h0005);
		@(posedge sys_clk);
		ext_en <= 5'h1A;
		tick(4);
		chk({15'h0000, chip}, 16'h0000);
		@(posedge sys_clk);
		ext_en <= 5'h0A;
		wait_run;
		chk({15'h0000, n > 31 && n < 40}, 16'h0001);
		rdc(`RPM_OFF_RST, 16'h0007);
		wr(`RPM_OFF_RST, 16'h000F);
		rdc(`RPM_OFF_RST, 16'h0000);
		wr(`RPM_OFF_RST, 16'h8000);
		tick(3);
		chk({15'h0000, chip}, 16'h0000);
		wait_run;
		rdc(`RPM_OFF_RST, 16'h0008);
		rdc(4'hF, 16'h0000);
		wr(`RPM_OFF_MUX, 16'h0080);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		tick(2);
		chk({5'h00, chip, oe, pu}, 16'h001F);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		wait_run;
		chk({15'h0000, n > 31 && n < 40}, 16'h0001);
		rdc(`RPM_OFF_MUX, 16'h0000);
		rdc(`RPM_OFF_RST, 16'h0001);
		tally_and_finish;
	end
endmodule
